/* verilog/swm_pkg.sv */
// Shared constants, command codes and carriers for the single-wire port config block.
// Assumes one 125 MHz clock and a host that issues commands over a valid/ready port.
// Overview of operation
// - Engine runs reset, byte, bit, triplet waveforms alone
// - Status shows done, presence, short, direction; data separate
// - Host port serves standard and fast mode hosts
// - Four readable registers chosen by read pointer
// - Last executed command sets the read pointer
// - Config and port config writable; others read only
// - Active, strong pullup and speed set independently
// - Strong pullup bit clears when its period ends
// - Reset leaves config register at zero
// - Config write needs upper nibble inverse of lower
// - Config read returns zero upper nibble
// - Active pullup bit selects transistor assist on rise
// - No active pullup after short recovery
// - Fixed pullup on reset cycle rising edges
// - Transistor stays on until slot end
// - Power-down stops all bus traffic until cleared
// - Power-down drops resistor and drives line low
// - Without power-down resistor keeps line high
// - Power-down plus strong pullup stores strong as zero
// - Sleep input low sleeps; power-down stays independent
// - Config bits: active, power-down, strong, speed
// - Speed bit selects standard or overdrive timing
// - Strong pullup ends on command, clear, reset
package swm_pkg;
	// Clock rate in MHz
	localparam int CLK_MHZ = 125;
	// Least time in ns to whole cycles, never below one
	function automatic int ns2cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction
	// Standard speed times in ns
	localparam int T_RSTL_STD_NS = 480000;
	localparam int T_MSP_STD_NS  = 70000;
	localparam int T_SI_STD_NS   = 8000;
	localparam int T_SLOT_STD_NS = 65000;
	localparam int T_W0L_STD_NS  = 60000;
	localparam int T_W1L_STD_NS  = 6000;
	localparam int T_MSR_STD_NS  = 15000;
	localparam int T_FIX_STD_NS  = 2500;
	// Overdrive speed times in ns
	localparam int T_RSTL_OD_NS  = 48000;
	localparam int T_MSP_OD_NS   = 8000;
	localparam int T_SI_OD_NS    = 1000;
	localparam int T_SLOT_OD_NS  = 10000;
	localparam int T_W0L_OD_NS   = 7500;
	localparam int T_W1L_OD_NS   = 1000;
	localparam int T_MSR_OD_NS   = 2000;
	localparam int T_FIX_OD_NS   = 500;
	// Counter width and slot counts; the counter must span twice the longest reset low
	localparam int CW = 17;
	localparam logic [3:0] SLOTS_BIT  = 4'h1;
	localparam logic [3:0] SLOTS_BYTE = 4'h8;
	localparam logic [3:0] SLOTS_TRIP = 4'h3;
	// Config field positions
	localparam int CFG_ACTIVE = 0;
	localparam int CFG_PWRDN  = 1;
	localparam int CFG_STRONG = 2;
	localparam int CFG_ODS    = 3;
	localparam logic [7:0] CFG_RST_VAL = 8'h00;
	// Status field positions
	localparam int ST_BUSY = 0;
	localparam int ST_PPD  = 1;
	localparam int ST_SD   = 2;
	localparam int ST_LL   = 3;
	localparam int ST_RST  = 4;
	localparam int ST_SBR  = 5;
	localparam int ST_TSB  = 6;
	localparam int ST_DIR  = 7;
	// Host commands
	typedef enum logic [3:0] {
		CMD_DEV_RESET, CMD_SET_PTR, CMD_WR_CFG, CMD_ADJ_PORT,
		CMD_BUS_RESET, CMD_BUS_BIT, CMD_BUS_WBYTE, CMD_BUS_RBYTE, CMD_BUS_TRIP
	} swm_cmd_e;
	// Read pointer targets
	typedef enum logic [1:0] {PTR_STATUS, PTR_DATA, PTR_CFG, PTR_PORT} swm_ptr_e;
	// Command carrier
	typedef struct packed {
		swm_cmd_e   code;
		logic [7:0] data;
	} swm_cmd_s;
endpackage

/* verilog/swm_cfg.sv */
// Single-wire master: command engine, config register, pullup and power control.
// Assumes the host decodes its serial transfers into commands and read strobes.
`timescale 1ns/1ns
module swm_cfg import swm_pkg::*; #(
	parameter int P_RSTL_STD = ns2cyc(T_RSTL_STD_NS),
	parameter int P_MSP_STD  = ns2cyc(T_MSP_STD_NS),
	parameter int P_SLOT_STD = ns2cyc(T_SLOT_STD_NS),
	parameter int P_W0L_STD  = ns2cyc(T_W0L_STD_NS)
) (
	// Clock and reset
	input  wire logic     clk_i,
	input  wire logic     rst_i,
	// Host command port
	input  wire logic     cmd_valid_i,
	input  wire swm_cmd_s cmd_i,
	output logic          cmd_ready_o,
	// Host read port
	input  wire logic     rd_req_i,
	output logic [7:0]    rd_data_o,
	// Single-wire line and power pins
	input  wire logic     io_i,
	output logic          io_pd_o,
	output logic          io_boost_o,
	output logic          res_pull_en_o,
	// Sleep control
	input  wire logic     sleep_input_n_i,
	output logic          asleep_o
);
	typedef enum {E_IDLE, E_RST, E_SLOT} swm_st_e;

	logic [1:0]    s1_q, s2_q, s3_q;   // Pin synchronisers: line, sleep
	logic          line_q, awake_q;    // Filtered pin levels
	logic          line_prev_q;        // For rising edge detect
	logic [3:0]    cfg_q;              // Active, power-down, strong, speed
	logic [3:0]    port_q;             // Port parameter code
	swm_ptr_e      ptr_q;              // Read pointer
	logic [7:0]    stat_q;             // Status register
	logic [7:0]    rdat_q;             // Read data register
	logic [7:0]    rd_q;               // Read output flop
	swm_st_e       st_q;               // Engine state
	logic [CW-1:0] cnt_q;              // Time in current slot
	logic [3:0]    rem_q;              // Slots left
	logic [7:0]    sh_q;               // Bits out / in
	logic          trip_q, tdir_q;     // Triplet mode, preferred direction
	logic          rbyte_q;            // Read byte in progress
	logic          samp_q;             // Line sample of this slot
	logic          short_q;            // Short seen this reset cycle
	logic          boost_slot_q;       // Transistor held to slot end
	logic [CW-1:0] fix_q;              // Fixed pullup time left
	logic          strong_on_q;        // Strong pullup running
	logic [CW-1:0] t_rstl, t_msp, t_si, t_slot, t_w0l, t_w1l, t_msr, t_fix, t_low;
	logic          take, devrst, bus_cmd, bus_take, cfg_ok, cfg_take;
	logic          slot_end, rst_end, done, dir_w, strong_stop, rise;

	// Timing set follows the speed bit
	always_comb begin
		if (cfg_q[CFG_ODS]) begin
			t_rstl = CW'(ns2cyc(T_RSTL_OD_NS));
			t_msp  = CW'(ns2cyc(T_MSP_OD_NS));
			t_si   = CW'(ns2cyc(T_SI_OD_NS));
			t_slot = CW'(ns2cyc(T_SLOT_OD_NS));
			t_w0l  = CW'(ns2cyc(T_W0L_OD_NS));
			t_w1l  = CW'(ns2cyc(T_W1L_OD_NS));
			t_msr  = CW'(ns2cyc(T_MSR_OD_NS));
			t_fix  = CW'(ns2cyc(T_FIX_OD_NS));
		end else begin
			t_rstl = CW'(P_RSTL_STD);
			t_msp  = CW'(P_MSP_STD);
			t_si   = CW'(ns2cyc(T_SI_STD_NS));
			t_slot = CW'(P_SLOT_STD);
			t_w0l  = CW'(P_W0L_STD);
			t_w1l  = CW'(ns2cyc(T_W1L_STD_NS));
			t_msr  = CW'(ns2cyc(T_MSR_STD_NS));
			t_fix  = CW'(ns2cyc(T_FIX_STD_NS));
		end
		t_low = sh_q[0] ? t_w1l : t_w0l;
	end

	// Command decode; sleep or a running waveform holds the host off
	assign cmd_ready_o = awake_q && (st_q == E_IDLE);
	assign take     = cmd_valid_i && cmd_ready_o;
	assign devrst   = take && (cmd_i.code == CMD_DEV_RESET);
	assign bus_cmd  = cmd_i.code inside {CMD_BUS_RESET, CMD_BUS_BIT,
		CMD_BUS_WBYTE, CMD_BUS_RBYTE, CMD_BUS_TRIP};
	// Power-down swallows every bus command
	assign bus_take = take && bus_cmd && !cfg_q[CFG_PWRDN];
	assign cfg_ok   = (cmd_i.data[7:4] == ~cmd_i.data[3:0]);
	assign cfg_take = take && (cmd_i.code == CMD_WR_CFG) && cfg_ok;
	assign rst_end  = (st_q == E_RST) && (cnt_q == 2 * t_rstl - 1'b1);
	assign slot_end = (st_q == E_SLOT) && (cnt_q == t_slot - 1'b1);
	assign done     = rst_end || (slot_end && rem_q == SLOTS_BIT);
	// Search direction from the two read bits
	assign dir_w = (stat_q[ST_SBR] ^ samp_q) ? stat_q[ST_SBR]
		: (stat_q[ST_SBR] | tdir_q);
	assign rise  = line_q && !line_prev_q;

	// Three-flop pin filter; level moves once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q        <= 2'h3;
			s2_q        <= 2'h3;
			s3_q        <= 2'h3;
			line_q      <= 1'b1;
			awake_q     <= 1'b1;
			line_prev_q <= 1'b1;
		end else begin
			s1_q <= {sleep_input_n_i, io_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q[0] == s3_q[0])
				line_q <= s3_q[0];
			if (s2_q[1] == s3_q[1])
				awake_q <= s3_q[1];
			line_prev_q <= line_q;
		end
	end

	// Waveform engine: runs every slot without host help
	always_ff @(posedge clk_i) begin
		if (rst_i || devrst) begin
			st_q    <= E_IDLE;
			cnt_q   <= '0;
			rem_q   <= '0;
			sh_q    <= '0;
			trip_q  <= 1'b0;
			tdir_q  <= 1'b0;
			rbyte_q <= 1'b0;
			samp_q  <= 1'b0;
		end else begin
			case (st_q)
				E_IDLE: begin
					cnt_q <= '0;
					if (bus_take) begin
						trip_q  <= (cmd_i.code == CMD_BUS_TRIP);
						rbyte_q <= (cmd_i.code == CMD_BUS_RBYTE);
						tdir_q  <= cmd_i.data[7];
						case (cmd_i.code)
							CMD_BUS_RESET: st_q <= E_RST;
							CMD_BUS_BIT: begin
								st_q  <= E_SLOT;
								rem_q <= SLOTS_BIT;
								sh_q  <= {7'h00, cmd_i.data[7]};
							end
							CMD_BUS_WBYTE: begin
								st_q  <= E_SLOT;
								rem_q <= SLOTS_BYTE;
								sh_q  <= cmd_i.data;
							end
							CMD_BUS_RBYTE: begin
								st_q  <= E_SLOT;
								rem_q <= SLOTS_BYTE;
								sh_q  <= 8'hFF;
							end
							default: begin
								st_q  <= E_SLOT;
								rem_q <= SLOTS_TRIP;
								sh_q  <= 8'hFF;
							end
						endcase
					end
				end
				E_RST: begin
					cnt_q <= cnt_q + 1'b1;
					if (rst_end)
						st_q <= E_IDLE;
				end
				E_SLOT: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == t_msr)
						samp_q <= line_q;
					if (slot_end) begin
						cnt_q <= '0;
						rem_q <= rem_q - 1'b1;
						// Triplet third slot writes the chosen direction
						if (trip_q && rem_q == SLOTS_TRIP - 1'b1)
							sh_q <= {7'h7F, dir_w};
						else
							sh_q <= {samp_q, sh_q[7:1]};
						if (rem_q == SLOTS_BIT)
							st_q <= E_IDLE;
					end
				end
				default: st_q <= E_IDLE;
			endcase
		end
	end

	// Status and received data
	always_ff @(posedge clk_i) begin
		if (rst_i || devrst) begin
			stat_q         <= '0;
			stat_q[ST_RST] <= 1'b1;
			rdat_q         <= '0;
		end else begin
			stat_q[ST_BUSY] <= (st_q != E_IDLE) && !done;
			if (bus_take)
				stat_q[ST_BUSY] <= 1'b1;
			if (cfg_take)
				stat_q[ST_RST] <= 1'b0;
			if (st_q == E_RST && cnt_q == t_rstl + t_si)
				stat_q[ST_SD] <= !line_q;
			if (st_q == E_RST && cnt_q == t_rstl + t_msp)
				stat_q[ST_PPD] <= !line_q;
			if (rd_req_i && ptr_q == PTR_STATUS)
				stat_q[ST_LL] <= line_q;
			if (slot_end && !rbyte_q) begin
				if (!trip_q || rem_q == SLOTS_TRIP)
					stat_q[ST_SBR] <= samp_q;
				if (trip_q && rem_q == SLOTS_TRIP - 1'b1) begin
					stat_q[ST_TSB] <= samp_q;
					stat_q[ST_DIR] <= dir_w;
				end
			end
			if (slot_end && rbyte_q && rem_q == SLOTS_BIT)
				rdat_q <= {samp_q, sh_q[7:1]};
		end
	end

	// Config and port registers; strong pullup end clears its own bit
	always_ff @(posedge clk_i) begin
		if (rst_i || devrst) begin
			cfg_q  <= CFG_RST_VAL[3:0];
			port_q <= '0;
		end else begin
			if (strong_stop)
				cfg_q[CFG_STRONG] <= 1'b0;
			if (cfg_take) begin
				cfg_q <= cmd_i.data[3:0];
				// Power-down and strong pullup together keep strong off
				if (cmd_i.data[CFG_PWRDN])
					cfg_q[CFG_STRONG] <= 1'b0;
			end
			if (take && cmd_i.code == CMD_ADJ_PORT)
				port_q <= cmd_i.data[3:0];
		end
	end

	// Read pointer follows the last command taken, bus commands swallowed in power-down leave it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ptr_q <= PTR_STATUS;
		end else if (take) begin
			case (cmd_i.code)
				CMD_SET_PTR:  ptr_q <= swm_ptr_e'(cmd_i.data[1:0]);
				CMD_WR_CFG:   ptr_q <= PTR_CFG;
				CMD_ADJ_PORT: ptr_q <= PTR_PORT;
				default: begin
					if (!bus_cmd || bus_take)
						ptr_q <= PTR_STATUS;
				end
			endcase
		end
	end

	// Read mux registered; config upper nibble always reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_q <= '0;
		end else begin
			case (ptr_q)
				PTR_STATUS: rd_q <= stat_q;
				PTR_DATA:   rd_q <= rdat_q;
				PTR_CFG:    rd_q <= {4'h0, cfg_q};
				default:    rd_q <= {4'h0, port_q};
			endcase
		end
	end
	assign rd_data_o = rd_q;

	// Strong pullup runs from command end until the next stop event;
	// a power-down write stops it too, since that write forces its bit off
	assign strong_stop = strong_on_q && (bus_take || devrst
		|| (cfg_take && (!cmd_i.data[CFG_STRONG] || cmd_i.data[CFG_PWRDN])));
	always_ff @(posedge clk_i) begin
		if (rst_i || strong_stop) begin
			strong_on_q <= 1'b0;
		end else if (done && cfg_q[CFG_STRONG] && !cfg_q[CFG_PWRDN]) begin
			strong_on_q <= 1'b1;
		end
	end

	// Active pullup: slot hold past threshold, fixed burst in reset cycle
	always_ff @(posedge clk_i) begin
		if (rst_i || devrst) begin
			boost_slot_q <= 1'b0;
			fix_q        <= '0;
			short_q      <= 1'b0;
		end else begin
			if (bus_take)
				short_q <= 1'b0;
			if (st_q == E_RST && cnt_q == t_rstl + t_si && !line_q)
				short_q <= 1'b1;
			// Line high stands in for the activation threshold
			if (st_q == E_SLOT && cnt_q >= t_low && line_q && cfg_q[CFG_ACTIVE])
				boost_slot_q <= 1'b1;
			if (slot_end || st_q != E_SLOT)
				boost_slot_q <= 1'b0;
			if (fix_q != '0)
				fix_q <= fix_q - 1'b1;
			if (st_q == E_RST && cnt_q >= t_rstl && rise && cfg_q[CFG_ACTIVE] && !short_q)
				fix_q <= t_fix;
			if (short_q)
				fix_q <= '0;
		end
	end

	// Pin drive: power-down pulls low and drops the resistor, sleep or not
	assign io_pd_o       = cfg_q[CFG_PWRDN] || (st_q == E_RST && cnt_q < t_rstl)
		|| (st_q == E_SLOT && cnt_q < t_low);
	assign res_pull_en_o = !cfg_q[CFG_PWRDN];
	assign io_boost_o    = !cfg_q[CFG_PWRDN]
		&& (boost_slot_q || fix_q != '0 || strong_on_q);
	assign asleep_o  = !awake_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_cfg_good;
		take && cmd_i.code == CMD_WR_CFG && cfg_ok;
	endsequence
	sequence s_cfg_bad;
		take && cmd_i.code == CMD_WR_CFG && !cfg_ok;
	endsequence

	cfg_write_a: assert property (s_cfg_good |=>
		cfg_q == ($past(cmd_i.data[3:0]) & ~($past(cmd_i.data[1]) ? 4'h4 : 4'h0)))
		else $error("config write not stored");
	cfg_reject_a: assert property (s_cfg_bad |=> $stable(cfg_q))
		else $error("bad config write changed register");
	pwrdn_line_a: assert property (cfg_q[CFG_PWRDN] |-> io_pd_o && !res_pull_en_o && !io_boost_o)
		else $error("power-down line not low");
	pwrdn_quiet_a: assert property (cfg_q[CFG_PWRDN] && st_q == E_IDLE |=> st_q == E_IDLE)
		else $error("bus traffic in power-down");
	cfg_upper_a: assert property (ptr_q == PTR_CFG ##1 ptr_q == PTR_CFG |-> rd_data_o[7:4] == 4'h0)
		else $error("config upper nibble not zero");
	ptr_bus_a: assert property (bus_take |=> ptr_q == PTR_STATUS && st_q != E_IDLE)
		else $error("pointer not at status after bus command");
	strong_clear_a: assert property ($fell(strong_on_q) |-> !cfg_q[CFG_STRONG])
		else $error("strong bit stayed after pullup end");
	dev_reset_a: assert property (devrst |=> cfg_q == 4'h0 ##1 rd_data_o[ST_RST] || ptr_q != PTR_STATUS)
		else $error("device reset left config set");
	short_boost_a: assert property (short_q && st_q == E_RST |-> fix_q == '0)
		else $error("active pullup after short");
	sleep_hold_a: assert property (!awake_q |-> !cmd_ready_o)
		else $error("command taken in sleep");
endmodule // swm_cfg

/* bench/swm_slave_model.sv */
// Behavioural single-wire slave for the port config block's line.
// Assumes the bench joins line_o to io_i and the port pins to its inputs.
`timescale 1ns/1ns
module swm_slave_model (
	// Clock
	input  wire logic       clk_i,
	// Port pins of the master
	input  wire logic       pd_i,
	input  wire logic       boost_i,
	input  wire logic       res_i,
	// Bench controls
	input  wire logic       present_i,
	input  wire logic       short_i,
	input  wire logic       tx_en_i,
	input  wire logic [7:0] tx_byte_i,
	// Line and captured byte
	output logic            line_o,
	output logic [7:0]      rx_byte_o
);
	int         t_q = 0;      // Cycles since last fall
	int         r_q = 0;      // Cycles since last rise
	int         low_q = 0;    // Length of current low
	logic       prev_q = 1'b1;
	logic       rst_q = 1'b0; // Last low was a reset pulse
	logic       hold_q = 1'b0;
	logic       slv_q = 1'b0;
	logic       flip_q = 1'b0;
	logic [2:0] bit_q = 3'h0;
	// Undriven line with no resistor toggles so no stale level hides a fault
	always_comb begin
		if (pd_i || slv_q || short_i) line_o = 1'b0;
		else if (res_i || boost_i) line_o = 1'b1;
		else line_o = flip_q;
	end
	// Slot timing: reset seen at 2500 or more low cycles, sample at 1000 after fall
	always_ff @(posedge clk_i) begin
		flip_q <= ~flip_q;
		prev_q <= line_o;
		low_q  <= line_o ? 0 : low_q + 1;
		t_q    <= (prev_q && !line_o) ? 0 : t_q + 1;
		if (line_o && !prev_q) begin
			rst_q <= (low_q >= 2500);
			r_q   <= 0;
		end else r_q <= r_q + 1;
		if (prev_q && !line_o) hold_q <= tx_en_i && !tx_byte_i[bit_q];
		if (t_q == 1000) rx_byte_o <= {line_o, rx_byte_o[7:1]};
		if (!tx_en_i) bit_q <= 3'h0;
		else if (t_q == 1000) bit_q <= bit_q + 3'h1;
		// Presence window after the reset rise, read-zero hold past sampling
		slv_q <= (present_i && rst_q && r_q >= 1100 && r_q < 1800) || (hold_q && t_q < 2100);
	end
endmodule // swm_slave_model

/* bench/tb_swm_cfg.sv */
// Self-checking bench for the single-wire port config block.
// Assumes shortened reset, presence and slot counts set at the instance.
`timescale 1ns/1ns
module tb_swm_cfg;
	import swm_pkg::*;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
	$display("[FAIL] %0t got %h want %h", $time, a, e); end end
	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       cmd_valid_i = 1'b0;
	swm_cmd_s   cmd_i = '0;
	logic       cmd_ready_o;
	logic       rd_req_i = 1'b0;
	logic [7:0] rd_data_o;
	logic       io_i, io_pd_o, io_boost_o, res_pull_en_o, asleep_o;
	logic       sleep_input_n_i = 1'b1;
	logic       present = 1'b0, short = 1'b0, tx_en = 1'b0;
	logic [7:0] tx_byte = 8'h00, rx_byte, b;
	logic       look = 1'b0, boost_seen = 1'b0;
	logic [7:0] want;
	logic [7:0] q[$];
	logic [3:0] n;
	int         failures = 0, checks_done = 0, pd_run = 0, pd_width = 0;
	// 125 MHz clock
	initial forever #4 clk_i = ~clk_i;
	// Block under test with short counts so a reset takes 6000 cycles
	swm_cfg #(.P_RSTL_STD(3000), .P_MSP_STD(1300), .P_SLOT_STD(2400), .P_W0L_STD(2000)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
		.cmd_ready_o(cmd_ready_o), .rd_req_i(rd_req_i), .rd_data_o(rd_data_o),
		.io_i(io_i), .io_pd_o(io_pd_o), .io_boost_o(io_boost_o),
		.res_pull_en_o(res_pull_en_o),
		.sleep_input_n_i(sleep_input_n_i), .asleep_o(asleep_o));
	// Slave on the line
	swm_slave_model u_slave (
		.clk_i(clk_i), .pd_i(io_pd_o), .boost_i(io_boost_o), .res_i(res_pull_en_o),
		.present_i(present), .short_i(short), .tx_en_i(tx_en), .tx_byte_i(tx_byte),
		.line_o(io_i), .rx_byte_o(rx_byte));
	// Output watcher: compares read data against the oldest note
	// The note is popped once, so a failing line prints the value it compared
	always @(posedge clk_i) begin
		if (look) begin
			want = q.pop_front();
			`CHK(rd_data_o, want)
		end
	end
	// Pulldown length and transistor activity monitors
	always @(posedge clk_i) begin
		if (io_pd_o === 1'b1) pd_run++;
		else if (pd_run != 0) begin
			pd_width = pd_run;
			pd_run = 0;
		end
		if (io_boost_o === 1'b1) boost_seen = 1'b1;
	end
	// Command handshake, held until a ready edge takes it
	task automatic cmd(input swm_cmd_e c, input logic [7:0] d);
		int k;
		k = 0;
		@(negedge clk_i);
		cmd_valid_i = 1'b1;
		cmd_i = '{c, d};
		while (cmd_ready_o !== 1'b1 && k < 30000) begin
			@(negedge clk_i);
			k++;
		end
		if (k >= 30000) `CHK(k, 0)
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
	endtask
	// Config write with the checked upper nibble
	task automatic wcfg(input logic [3:0] v);
		cmd(CMD_WR_CFG, {~v, v});
	endtask
	// Wait for the engine to finish, bounded
	task automatic wait_idle();
		int k;
		k = 0;
		@(negedge clk_i);
		while (cmd_ready_o !== 1'b1 && k < 30000) begin
			@(negedge clk_i);
			k++;
		end
		if (k >= 30000) `CHK(k, 0)
	endtask
	// Note a value, then let the watcher compare it
	task automatic peek(input logic [7:0] e);
		q.push_back(e);
		@(negedge clk_i);
		look = 1'b1;
		@(negedge clk_i);
		look = 0;
	endtask
	// Point at a register, strobe a read, then compare
	task automatic rdreg(input swm_ptr_e p, input logic [7:0] e);
		cmd(CMD_SET_PTR, {6'h00, p});
		rd_req_i = 1'b1;
		@(negedge clk_i);
		rd_req_i = 1'b0;
		repeat (2) @(negedge clk_i);
		peek(e);
	endtask
	// Count summary and verdict
	task automatic results();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (95000) @(posedge clk_i);
		failures++;
		results();
	end
	// Main sequence
	initial begin
		void'($urandom(48611));
		repeat (10) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		rdreg(PTR_CFG, 8'h00);
		rdreg(PTR_STATUS, 8'h18);
		`CHK({res_pull_en_o, io_pd_o}, 2'b10)
		$display("test reset done");
		// Feature combinations, power-down with strong pullup first
		for (int i = 0; i < 8; i++) begin
			n = (i == 0) ? 4'h6 : (i == 1) ? 4'hD : 4'($urandom % 16);
			wcfg(n);
			rdreg(PTR_CFG, {4'h0, (n[1] && n[2]) ? (n & 4'hB) : n});
		end
		wcfg(4'h9);
		cmd(CMD_WR_CFG, 8'h3D);
		rdreg(PTR_CFG, 8'h09);
		wcfg(4'h0);
		repeat (2500) @(negedge clk_i);
		$display("test config done");
		// Power-down, an ignored bus reset, and sleep on top of it
		wcfg(4'h2);
		`CHK({res_pull_en_o, io_pd_o}, 2'b01)
		cmd(CMD_BUS_RESET, 8'h00);
		repeat (20) @(negedge clk_i);
		`CHK({cmd_ready_o, io_pd_o}, 2'b11)
		sleep_input_n_i = 1'b0;
		repeat (8) @(negedge clk_i);
		`CHK({asleep_o, cmd_ready_o, io_pd_o}, 3'b101)
		sleep_input_n_i = 1'b1;
		repeat (8) @(negedge clk_i);
		wcfg(4'h0);
		`CHK({res_pull_en_o, io_pd_o, asleep_o}, 3'b100)
		sleep_input_n_i = 1'b0;
		repeat (8) @(negedge clk_i);
		`CHK({asleep_o, res_pull_en_o, io_pd_o}, 3'b110)
		sleep_input_n_i = 1'b1;
		repeat (2500) @(negedge clk_i);
		rdreg(PTR_STATUS, 8'h08);
		$display("test power done");
		// Bus reset with presence and active pullup
		wcfg(4'h1);
		present = 1'b1;
		boost_seen = 1'b0;
		cmd(CMD_BUS_RESET, 8'h00);
		wait_idle();
		`CHK(pd_width, 3000)
		`CHK(boost_seen, 1'b1)
		peek(8'h0A);
		// Strong pullup armed: resistor only in the reset, transistor once it ends
		wcfg(4'h4);
		rdreg(PTR_CFG, 8'h04);
		present = 1'b0;
		boost_seen = 1'b0;
		cmd(CMD_BUS_RESET, 8'h00);
		wait_idle();
		`CHK(boost_seen, 1'b0)
		@(negedge clk_i);
		`CHK(io_boost_o, 1'b1)
		rdreg(PTR_CFG, 8'h04);
		rdreg(PTR_STATUS, 8'h08);
		// Shorted line; its bus command also ends the strong pullup
		short = 1'b1;
		cmd(CMD_BUS_RESET, 8'h00);
		wait_idle();
		rdreg(PTR_STATUS, 8'h06);
		rdreg(PTR_CFG, 8'h00);
		short = 1'b0;
		repeat (2500) @(negedge clk_i);
		$display("test bus reset done");
		// Byte write and byte read
		b = 8'($urandom);
		cmd(CMD_BUS_WBYTE, b);
		wait_idle();
		`CHK(rx_byte, b)
		b = 8'($urandom);
		tx_byte = b;
		tx_en = 1'b1;
		cmd(CMD_BUS_RBYTE, 8'h00);
		wait_idle();
		tx_en = 1'b0;
		rdreg(PTR_DATA, b);
		$display("test bytes done");
		// Overdrive reset pulse length
		wcfg(4'h8);
		cmd(CMD_BUS_RESET, 8'h00);
		wait_idle();
		`CHK(pd_width, T_RSTL_OD_NS * CLK_MHZ / 1000)
		// Triplet with no slave answer: both reads 1, direction 1
		cmd(CMD_BUS_TRIP, 8'h00);
		wait_idle();
		rdreg(PTR_STATUS, 8'hE8);
		$display("test speed done");
		// Port code, then strong pullup after a single bit ended by device reset
		cmd(CMD_ADJ_PORT, 8'h0B);
		peek(8'h0B);
		wcfg(4'h4);
		cmd(CMD_BUS_BIT, 8'h80);
		wait_idle();
		@(negedge clk_i);
		`CHK(io_boost_o, 1'b1)
		cmd(CMD_DEV_RESET, 8'h00);
		`CHK(io_boost_o, 1'b0)
		peek(8'h10);
		rdreg(PTR_CFG, 8'h00);
		$display("test commands done");
		results();
	end
endmodule // tb_swm_cfg
